/* File: bpu_pkg.sv */
package bpu_pkg;

    localparam int ADDR_W            = 32;
    localparam int TAT_ENTRIES       = 2048;
    localparam int TAT_IDX_W         = 11;
    localparam int DIR_ENTRIES       = 16384;
    localparam int DIR_IDX_W         = 14;
    localparam int HIST_W            = 14;
    localparam int IND_ENTRIES       = 512;
    localparam int IND_IDX_W         = 9;
    localparam int RAS_DEPTH         = 24;
    localparam int RAS_PTR_W         = 5;
    localparam int SEL_W             = 16;
    localparam int PREDEC_W          = 64;
    localparam int MISPREDICT_CYCLES = 10;

    localparam logic [RAS_PTR_W-1:0] RAS_LAST    = 5'h17;
    localparam logic [RAS_PTR_W-1:0] RAS_FULL    = 5'h18;
    localparam logic [1:0]           CTR_RESET   = 2'h1;
    localparam logic [HIST_W-1:0]    HIST_RESET  = 14'h0000;
    localparam logic [3:0]           RECOVER_CNT = 4'(MISPREDICT_CYCLES - 2);

    typedef enum logic [1:0] {PH_UNSEEN, PH_TAKEN_ONCE, PH_DYNAMIC} phase_e;
    typedef enum logic [2:0] {BK_NONE, BK_COND, BK_JUMP, BK_CALL, BK_RET, BK_IND} br_kind_e;
    typedef enum logic {RC_RUN, RC_WAIT} rec_e;

    typedef struct packed {
        logic              valid;
        br_kind_e          kind;
        logic [ADDR_W-1:0] pc;
        logic [ADDR_W-1:0] next_pc;
    } fetch_req_s;

    typedef struct packed {
        logic              valid;
        logic              taken;
        logic [ADDR_W-1:0] target;
        logic [HIST_W-1:0] hist;
    } pred_s;

    typedef struct packed {
        logic              valid;
        br_kind_e          kind;
        logic [ADDR_W-1:0] pc;
        logic              taken;
        logic              mispredict;
        logic [ADDR_W-1:0] correct_pc;
        logic [HIST_W-1:0] hist;
    } resolve_s;

    typedef struct packed {
        logic              valid;
        logic [ADDR_W-1:0] addr;
        logic [SEL_W-1:0]  sel;
        logic [PREDEC_W-1:0] predec;
    } evict_s;

    typedef struct packed {
        logic              valid;
        logic [ADDR_W-1:0] target;
    } redirect_s;

endpackage

/* File: branch_prediction_unit.sv */
`timescale 1ns/1ps
module branch_prediction_unit (
    // clock and reset
    input  wire logic                  clk_in,
    input  wire logic                  rst_b_in,
    // fetch lookup, issued alongside the instruction cache access
    input  wire bpu_pkg::fetch_req_s   req_in,
    output bpu_pkg::pred_s             pred_out,
    // resolved outcomes from the back end
    input  wire bpu_pkg::resolve_s     res_in,
    output bpu_pkg::redirect_s         redirect_out,
    output logic                       recovering_out,
    // instruction cache eviction towards the second level
    input  wire bpu_pkg::evict_s       evict_in,
    output bpu_pkg::evict_s            l2_save_out
);

    function automatic logic [bpu_pkg::TAT_IDX_W-1:0] tat_index(input logic [bpu_pkg::ADDR_W-1:0] pc);
        tat_index = pc[bpu_pkg::TAT_IDX_W+1:2];
    endfunction

    function automatic logic [bpu_pkg::DIR_IDX_W-1:0] dir_index(input logic [bpu_pkg::ADDR_W-1:0] pc,
                                                                 input logic [bpu_pkg::HIST_W-1:0] h);
        dir_index = pc[bpu_pkg::DIR_IDX_W+1:2] ^ h;
    endfunction

    function automatic logic [bpu_pkg::IND_IDX_W-1:0] ind_index(input logic [bpu_pkg::ADDR_W-1:0] pc);
        ind_index = pc[bpu_pkg::IND_IDX_W+1:2];
    endfunction

    // tables
    bpu_pkg::phase_e         phase_q [bpu_pkg::TAT_ENTRIES];
    logic [bpu_pkg::ADDR_W-1:0] tat_tgt [bpu_pkg::TAT_ENTRIES];
    logic [1:0]              ctr_q   [bpu_pkg::DIR_ENTRIES];
    logic [bpu_pkg::ADDR_W-1:0] ind_tgt [bpu_pkg::IND_ENTRIES];
    logic [bpu_pkg::IND_ENTRIES-1:0] ind_vld_q;
    logic [bpu_pkg::ADDR_W-1:0] ras     [bpu_pkg::RAS_DEPTH];

    // control state
    logic [bpu_pkg::HIST_W-1:0]    ghist_q, ghist_d;
    logic [bpu_pkg::RAS_PTR_W-1:0] ras_ptr_q, ras_ptr_d;
    logic [bpu_pkg::RAS_PTR_W-1:0] ras_cnt_q, ras_cnt_d;
    logic [bpu_pkg::RAS_PTR_W-1:0] ras_top;
    bpu_pkg::rec_e                 rec_q, rec_d;
    logic [3:0]                    rcnt_q, rcnt_d;
    logic [bpu_pkg::ADDR_W-1:0]    rtgt_q, rtgt_d;
    bpu_pkg::pred_s                pred_q, pred_d;
    bpu_pkg::redirect_s            redir_q, redir_d;
    bpu_pkg::evict_s               save_q, save_d;

    // table write controls
    logic                          ph_we, tgt_we, ctr_we, ind_we, ras_we;
    bpu_pkg::phase_e               ph_wd;
    logic [1:0]                    ctr_wd;
    logic [bpu_pkg::TAT_IDX_W-1:0] rt, lt;
    logic [bpu_pkg::DIR_IDX_W-1:0] rd, ld;
    logic [bpu_pkg::IND_IDX_W-1:0] ri, li;
    logic                          run;
    logic                          cond_taken;

    assign pred_out       = pred_q;
    assign redirect_out   = redir_q;
    assign l2_save_out    = save_q;
    assign recovering_out = (rec_q == bpu_pkg::RC_WAIT);

    assign lt      = tat_index(req_in.pc);
    assign ld      = dir_index(req_in.pc, ghist_q);
    assign li      = ind_index(req_in.pc);
    assign rt      = tat_index(res_in.pc);
    assign rd      = dir_index(res_in.pc, res_in.hist);
    assign ri      = ind_index(res_in.pc);
    assign ras_top = (ras_ptr_q == '0) ? bpu_pkg::RAS_LAST : ras_ptr_q - 5'h01;
    // wrong-path fetch is dropped from the mispredict cycle until the redirect
    assign run     = (rec_q == bpu_pkg::RC_RUN) && !(res_in.valid && res_in.mispredict);

    // lookup: answered from flops on the edge after the request, same slot as the cache read
    always_comb begin
        pred_d        = '0;
        pred_d.hist   = ghist_q;
        pred_d.target = req_in.next_pc;
        cond_taken    = (phase_q[lt] == bpu_pkg::PH_TAKEN_ONCE) ||
                        (phase_q[lt] == bpu_pkg::PH_DYNAMIC && ctr_q[ld][1]);
        if (req_in.valid && run) begin
            pred_d.valid = 1'b1;
            unique case (req_in.kind)
                bpu_pkg::BK_COND: begin
                    pred_d.taken = cond_taken;
                    if (cond_taken) begin
                        pred_d.target = tat_tgt[lt];
                    end
                end
                bpu_pkg::BK_JUMP, bpu_pkg::BK_CALL: begin
                    // direct target unknown until the first resolution fills the table
                    pred_d.taken = (phase_q[lt] != bpu_pkg::PH_UNSEEN);
                    if (pred_d.taken) begin
                        pred_d.target = tat_tgt[lt];
                    end
                end
                bpu_pkg::BK_RET: begin
                    pred_d.taken = (ras_cnt_q != '0);
                    if (pred_d.taken) begin
                        pred_d.target = ras[ras_top];
                    end
                end
                bpu_pkg::BK_IND: begin
                    pred_d.taken = ind_vld_q[li];
                    if (pred_d.taken) begin
                        pred_d.target = ind_tgt[li];
                    end
                end
                bpu_pkg::BK_NONE: begin
                    pred_d.taken = 1'b0;
                end
                default: begin
                    pred_d.taken = 1'b0;
                end
            endcase
        end
    end

    // history and return stack
    always_comb begin
        ghist_d   = ghist_q;
        ras_ptr_d = ras_ptr_q;
        ras_cnt_d = ras_cnt_q;
        ras_we    = 1'b0;
        if (res_in.valid && res_in.mispredict) begin
            ghist_d = {res_in.hist[bpu_pkg::HIST_W-2:0], res_in.taken};
        end else if (pred_d.valid && req_in.kind == bpu_pkg::BK_COND) begin
            ghist_d = {ghist_q[bpu_pkg::HIST_W-2:0], pred_d.taken};
        end
        if (pred_d.valid && req_in.kind == bpu_pkg::BK_CALL) begin
            ras_we    = 1'b1;
            ras_ptr_d = (ras_ptr_q == bpu_pkg::RAS_LAST) ? '0 : ras_ptr_q + 5'h01;
            if (ras_cnt_q != bpu_pkg::RAS_FULL) begin
                ras_cnt_d = ras_cnt_q + 5'h01;
            end
        end else if (pred_d.valid && req_in.kind == bpu_pkg::BK_RET && ras_cnt_q != '0) begin
            ras_ptr_d = ras_top;
            ras_cnt_d = ras_cnt_q - 5'h01;
        end
    end

    // misprediction recovery and eviction save
    always_comb begin
        rec_d   = rec_q;
        rcnt_d  = rcnt_q;
        rtgt_d  = rtgt_q;
        redir_d = '0;
        save_d  = evict_in;
        if (res_in.valid && res_in.mispredict) begin
            rec_d  = bpu_pkg::RC_WAIT;
            rcnt_d = bpu_pkg::RECOVER_CNT;
            rtgt_d = res_in.correct_pc;
        end else if (rec_q == bpu_pkg::RC_WAIT) begin
            if (rcnt_q == '0) begin
                rec_d          = bpu_pkg::RC_RUN;
                redir_d.valid  = 1'b1;
                redir_d.target = rtgt_q;
            end else begin
                rcnt_d = rcnt_q - 4'h1;
            end
        end
    end

    // training from resolved branches
    always_comb begin
        ph_we  = 1'b0;
        tgt_we = 1'b0;
        ctr_we = 1'b0;
        ind_we = 1'b0;
        ph_wd  = phase_q[rt];
        ctr_wd = ctr_q[rd];
        if (res_in.valid) begin
            unique case (res_in.kind)
                bpu_pkg::BK_COND: begin
                    ph_we  = 1'b1;
                    tgt_we = res_in.taken;
                    ctr_we = 1'b1;
                    unique case (phase_q[rt])
                        bpu_pkg::PH_UNSEEN:     ph_wd = res_in.taken ? bpu_pkg::PH_TAKEN_ONCE : bpu_pkg::PH_UNSEEN;
                        bpu_pkg::PH_TAKEN_ONCE: ph_wd = res_in.taken ? bpu_pkg::PH_TAKEN_ONCE : bpu_pkg::PH_DYNAMIC;
                        default:                ph_wd = bpu_pkg::PH_DYNAMIC;
                    endcase
                    if (res_in.taken && ctr_q[rd] != 2'h3) begin
                        ctr_wd = ctr_q[rd] + 2'h1;
                    end else if (!res_in.taken && ctr_q[rd] != 2'h0) begin
                        ctr_wd = ctr_q[rd] - 2'h1;
                    end
                end
                bpu_pkg::BK_JUMP, bpu_pkg::BK_CALL: begin
                    ph_we  = 1'b1;
                    tgt_we = 1'b1;
                    ph_wd  = bpu_pkg::PH_DYNAMIC;
                end
                bpu_pkg::BK_IND: begin
                    ind_we = 1'b1;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ghist_q   <= bpu_pkg::HIST_RESET;
            ras_ptr_q <= '0;
            ras_cnt_q <= '0;
            rec_q     <= bpu_pkg::RC_RUN;
            rcnt_q    <= '0;
            rtgt_q    <= '0;
            pred_q    <= '0;
            redir_q   <= '0;
            save_q    <= '0;
            ind_vld_q <= '0;
            for (int i = 0; i < bpu_pkg::TAT_ENTRIES; i++) begin
                phase_q[i] <= bpu_pkg::PH_UNSEEN;
            end
            for (int i = 0; i < bpu_pkg::DIR_ENTRIES; i++) begin
                ctr_q[i] <= bpu_pkg::CTR_RESET;
            end
        end else begin
            ghist_q   <= ghist_d;
            ras_ptr_q <= ras_ptr_d;
            ras_cnt_q <= ras_cnt_d;
            rec_q     <= rec_d;
            rcnt_q    <= rcnt_d;
            rtgt_q    <= rtgt_d;
            pred_q    <= pred_d;
            redir_q   <= redir_d;
            save_q    <= save_d;
            if (ph_we) begin
                phase_q[rt] <= ph_wd;
            end
            if (ctr_we) begin
                ctr_q[rd] <= ctr_wd;
            end
            if (ind_we) begin
                ind_vld_q[ri] <= 1'b1;
            end
        end
    end

    // target storage needs no reset: every read is gated by a reset-cleared qualifier
    always_ff @(posedge clk_in) begin
        if (tgt_we) begin
            tat_tgt[rt] <= res_in.correct_pc;
        end
        if (ind_we) begin
            ind_tgt[ri] <= res_in.correct_pc;
        end
        if (ras_we) begin
            ras[ras_ptr_q] <= req_in.next_pc;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);

    lookup_one_cycle_a: assert property (
        req_in.valid && run |=> pred_q.valid)
        else $error("lookup not answered one cycle later");

    first_not_taken_a: assert property (
        req_in.valid && run && req_in.kind == bpu_pkg::BK_COND && phase_q[lt] == bpu_pkg::PH_UNSEEN
        |=> !pred_q.taken)
        else $error("unseen branch predicted taken");

    taken_redirect_a: assert property (
        req_in.valid && run && req_in.kind == bpu_pkg::BK_COND && phase_q[lt] == bpu_pkg::PH_TAKEN_ONCE
        |=> pred_q.taken && pred_q.target == $past(tat_tgt[lt]))
        else $error("once-taken branch not redirected to its target");

    recover_quiet_a: assert property (
        res_in.valid && res_in.mispredict |=> (!redir_q.valid)[*8] ##1 !redir_q.valid)
        else $error("redirect sooner than the misprediction penalty");

    recover_redirect_a: assert property (
        res_in.valid && res_in.mispredict ##1 (!(res_in.valid && res_in.mispredict))[*8]
        ##1 !(res_in.valid && res_in.mispredict)
        |=> redir_q.valid && redir_q.target == $past(res_in.correct_pc, 10))
        else $error("recovery redirect missing or wrong");

    hist_restore_a: assert property (
        res_in.valid && res_in.mispredict
        |=> ghist_q == {$past(res_in.hist[bpu_pkg::HIST_W-2:0]), $past(res_in.taken)})
        else $error("history not restored after misprediction");

    call_push_a: assert property (
        pred_d.valid && req_in.kind == bpu_pkg::BK_CALL
        |=> ras[$past(ras_ptr_q)] == $past(req_in.next_pc))
        else $error("call did not push its return address");

    return_pop_a: assert property (
        pred_d.valid && req_in.kind == bpu_pkg::BK_RET && ras_cnt_q != '0
        |=> pred_q.taken && pred_q.target == $past(ras[ras_top]) && ras_cnt_q == $past(ras_cnt_q) - 5'h01)
        else $error("return did not pop the stack top");

    stack_wrap_a: assert property (
        pred_d.valid && req_in.kind == bpu_pkg::BK_CALL && ras_ptr_q == bpu_pkg::RAS_LAST
        |=> ras_ptr_q == '0 && ras_cnt_q != '0)
        else $error("return stack did not wrap");

    evict_save_a: assert property (
        evict_in.valid |=> save_q.valid && save_q.sel == $past(evict_in.sel)
        && save_q.predec == $past(evict_in.predec))
        else $error("evicted line lost its branch information");

    cover property (res_in.valid && res_in.mispredict ##10 redir_q.valid);
    cover property (pred_q.valid && pred_q.taken && ghist_q[0]);
    cover property (pred_d.valid && req_in.kind == bpu_pkg::BK_CALL && ras_cnt_q == bpu_pkg::RAS_FULL);
    cover property (pred_d.valid && req_in.kind == bpu_pkg::BK_RET && ras_cnt_q != '0);

endmodule

/* File: fetch_backend_model.sv */
`timescale 1ns/1ps
module fetch_backend_model (
    // clock
    input  wire logic                clk_in,
    // towards the predictor
    output bpu_pkg::fetch_req_s      req_out,
    output bpu_pkg::resolve_s        res_out,
    output bpu_pkg::evict_s          evict_out,
    // answers from the predictor
    input  wire bpu_pkg::pred_s      pred_in
);
    initial begin
        req_out   = '0;
        res_out   = '0;
        evict_out = '0;
    end

    // the answer stands for one cycle only, so it is taken at the very next falling edge
    task automatic lookup(input bpu_pkg::br_kind_e kind, input logic [31:0] pc, input logic [31:0] next_pc,
                          output bpu_pkg::pred_s p);
        @(negedge clk_in);
        req_out = '{1'b1, kind, pc, next_pc};
        @(negedge clk_in);
        p = pred_in;
        // released fields stop showing the old address
        req_out = '{1'b0, kind, ~pc, ~next_pc};
    endtask

    task automatic resolve(input bpu_pkg::br_kind_e kind, input logic [31:0] pc, input logic taken,
                           input logic mis, input logic [31:0] correct, input logic [13:0] hist);
        @(negedge clk_in);
        res_out = '{1'b1, kind, pc, taken, mis, correct, hist};
        @(negedge clk_in);
        res_out = '{1'b0, kind, ~pc, ~taken, 1'b0, ~correct, ~hist};
    endtask

    task automatic evict(input bpu_pkg::evict_s e);
        @(negedge clk_in);
        evict_out = e;
        @(negedge clk_in);
        evict_out = bpu_pkg::evict_s'(~e);
    endtask
endmodule

/* File: branch_prediction_unit_tb.sv */
`timescale 1ns/1ps
module branch_prediction_unit_tb;
    logic                clk_in;
    logic                rst_b_in;
    bpu_pkg::fetch_req_s req;
    bpu_pkg::resolve_s   res;
    bpu_pkg::evict_s     evict;
    bpu_pkg::evict_s     l2_save;
    bpu_pkg::pred_s      pred;
    bpu_pkg::redirect_s  redirect;
    logic                recovering;
    int                  miscompares;
    int                  compares;

    initial clk_in = 1'b0;
    always #4 clk_in = ~clk_in;

    branch_prediction_unit dut (
        .clk_in         (clk_in),
        .rst_b_in       (rst_b_in),
        .req_in         (req),
        .pred_out       (pred),
        .res_in         (res),
        .redirect_out   (redirect),
        .recovering_out (recovering),
        .evict_in       (evict),
        .l2_save_out    (l2_save)
    );

    fetch_backend_model partner (
        .clk_in    (clk_in),
        .req_out   (req),
        .res_out   (res),
        .evict_out (evict),
        .pred_in   (pred)
    );

    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %0h want %0h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic expect_pred(input bpu_pkg::pred_s p, input logic taken, input logic [31:0] target);
        check(128'(p.valid), 128'h1);
        check(128'(p.taken), 128'(taken));
        check(128'(p.target), 128'(target));
    endtask

    // called at the first falling edge after the resolve edge
    task automatic expect_recovery(input logic [31:0] target);
        // recovering drops in the very cycle the redirect pulse stands
        for (int i = 1; i <= 10; i++) begin
            if (i > 1) @(negedge clk_in);
            check(128'(recovering), 128'(i < 10));
            check(128'(redirect.valid), 128'(i == 10));
        end
        check(128'(redirect.target), 128'(target));
        @(negedge clk_in);
        check(128'(recovering), 128'h0);
        check(128'(redirect.valid), 128'h0);
    endtask

    task automatic test_reset();
        check(128'(pred.valid), 128'h0);
        check(128'(redirect.valid), 128'h0);
        check(128'(recovering), 128'h0);
        check(128'(l2_save.valid), 128'h0);
        $display("test reset done");
    endtask

    task automatic test_direction_phases();
        bpu_pkg::pred_s p;
        partner.lookup(bpu_pkg::BK_COND, 32'h0000_1000, 32'h0000_1004, p);
        expect_pred(p, 1'b0, 32'h0000_1004);
        check(128'(p.hist), 128'h0);
        partner.resolve(bpu_pkg::BK_COND, 32'h0000_1000, 1'b1, 1'b1, 32'h0000_2000, 14'h0000);
        expect_recovery(32'h0000_2000);
        partner.lookup(bpu_pkg::BK_COND, 32'h0000_1000, 32'h0000_1004, p);
        expect_pred(p, 1'b1, 32'h0000_2000);
        check(128'(p.hist), 128'h0001);
        partner.resolve(bpu_pkg::BK_COND, 32'h0000_1000, 1'b0, 1'b1, 32'h0000_1004, 14'h0001);
        expect_recovery(32'h0000_1004);
        // dynamic phase: untouched counter at reset value predicts not taken
        partner.lookup(bpu_pkg::BK_COND, 32'h0000_1000, 32'h0000_1004, p);
        expect_pred(p, 1'b0, 32'h0000_1004);
        check(128'(p.hist), 128'h0002);
        // train the counter the next lookup will index with its shifted history
        partner.resolve(bpu_pkg::BK_COND, 32'h0000_1000, 1'b1, 1'b0, 32'h0000_2000, 14'h0004);
        partner.lookup(bpu_pkg::BK_COND, 32'h0000_1000, 32'h0000_1004, p);
        expect_pred(p, 1'b1, 32'h0000_2000);
        check(128'(p.hist), 128'h0004);
        $display("test direction phases done");
    endtask

    task automatic test_refused_lookup();
        bpu_pkg::pred_s p;
        partner.resolve(bpu_pkg::BK_JUMP, 32'h0000_3000, 1'b1, 1'b1, 32'h0000_3800, 14'h0000);
        partner.lookup(bpu_pkg::BK_COND, 32'h0000_1000, 32'h0000_1004, p);
        check(128'(p.valid), 128'h0);
        repeat (7) @(negedge clk_in);
        check(128'(redirect.valid), 128'h1);
        check(128'(redirect.target), 128'h0000_3800);
        partner.lookup(bpu_pkg::BK_JUMP, 32'h0000_3000, 32'h0000_3004, p);
        expect_pred(p, 1'b1, 32'h0000_3800);
        $display("test refused lookup done");
    endtask

    task automatic test_indirect();
        bpu_pkg::pred_s p;
        partner.lookup(bpu_pkg::BK_IND, 32'h0000_7000, 32'h0000_7004, p);
        expect_pred(p, 1'b0, 32'h0000_7004);
        partner.resolve(bpu_pkg::BK_IND, 32'h0000_7000, 1'b1, 1'b0, 32'h0000_9ABC, 14'h0000);
        partner.lookup(bpu_pkg::BK_IND, 32'h0000_7000, 32'h0000_7004, p);
        expect_pred(p, 1'b1, 32'h0000_9ABC);
        // same slot, but a plain instruction must never borrow the indirect target
        partner.lookup(bpu_pkg::BK_NONE, 32'h0000_7000, 32'h0000_7004, p);
        expect_pred(p, 1'b0, 32'h0000_7004);
        $display("test indirect done");
    endtask

    // one call more than the stack holds: the oldest return address is lost
    task automatic test_return_stack();
        bpu_pkg::pred_s p;
        for (int i = 0; i < 25; i++) begin
            partner.lookup(bpu_pkg::BK_CALL, 32'h0000_4000 + 32'(i * 8), 32'h0000_5000 + 32'(i * 16), p);
        end
        for (int i = 24; i >= 1; i--) begin
            partner.lookup(bpu_pkg::BK_RET, 32'h0000_6000, 32'h0000_6004, p);
            expect_pred(p, 1'b1, 32'h0000_5000 + 32'(i * 16));
        end
        partner.lookup(bpu_pkg::BK_RET, 32'h0000_6000, 32'h0000_6004, p);
        expect_pred(p, 1'b0, 32'h0000_6004);
        $display("test return stack done");
    endtask

    task automatic test_evict();
        bpu_pkg::evict_s e;
        e = '{1'b1, 32'h0001_2340, 16'hA5C3, 64'h0123_4567_89AB_CDEF};
        partner.evict(e);
        check(128'(l2_save), 128'(e));
        @(negedge clk_in);
        check(128'(l2_save.valid), 128'h0);
        $display("test evict done");
    endtask

    initial begin
        rst_b_in    = 1'b0;
        miscompares = 0;
        compares    = 0;
        repeat (5) @(negedge clk_in);
        test_reset();
        rst_b_in = 1'b1;
        test_direction_phases();
        test_refused_lookup();
        test_indirect();
        test_return_stack();
        test_evict();
        conclude();
    end

    initial begin
        repeat (20000) @(posedge clk_in);
        miscompares++;
        $display("unexpected at %0t: run did not finish", $time);
        conclude();
    end
endmodule
